// ==== hw/gdfp_map.svh ====
// constants for the gate driver fault protection block
// Summary of operation
// - supply low: gates off, pump off, fault low
// - supply low latches flags, auto resume
// - pump low: gates off, fault, auto resume
// - pump check off skips pump protection
// - drain overcurrent needs deglitch on enabled fet
// - pin variant: fixed deglitch, 4 ms retry
// - policy field selects overcurrent handling
// - latched policy: shutdown until clear
// - retry policy: resume after retry wait
// - report policy: gates run, fault reported
// - disabled policy: no drain action
// - shunt overcurrent needs deglitch time
// - pin variant shunt: fixed retry policy
// - shunt latched: shutdown until clear
// - shunt retry: resume after retry wait
// - shunt report: gates run, fault reported
// - shunt check off suppresses shunt only
// - gate stuck beyond timeout is fault
// - gate fault: shutdown until clear
// - gate check off disables gate detection
`ifndef GDFP_MAP_SVH
`define GDFP_MAP_SVH
`define GDFP_ADDR_CTRL       4'h0
`define GDFP_ADDR_CFG        4'h1
`define GDFP_ADDR_STATUS     4'h2
`define GDFP_ADDR_FET        4'h3
`define GDFP_CLK_MHZ         20
`define GDFP_DEG_HW_US       4
`define GDFP_RETRY_MS        4
`define GDFP_DEG_HW_CYC      (`GDFP_DEG_HW_US * `GDFP_CLK_MHZ)
`define GDFP_RETRY_CYC       (`GDFP_RETRY_MS * 1000 * `GDFP_CLK_MHZ)
`define GDFP_POL_LATCH       2'h0
`define GDFP_POL_RETRY       2'h1
`define GDFP_POL_REPORT      2'h2
`define GDFP_POL_OFF         2'h3
`define GDFP_CFG_RESET       11'h000
`define GDFP_CFG_POL_LSB     0
`define GDFP_CFG_PUMP_OFF    2
`define GDFP_CFG_SHUNT_OFF   3
`define GDFP_CFG_GATE_OFF    4
`define GDFP_CFG_DEG_LSB     5
`define GDFP_CFG_DRV_LSB     8
`define GDFP_CTRL_CLEAR      0
`endif

// ==== hw/gdfp_pkg.sv ====
// types for the gate driver fault protection block
package gdfp_pkg;
  typedef struct packed {
    logic       global;
    logic       supply_low;
    logic       pump_low;
    logic       drain_oc;
    logic       shunt_oc;
    logic       gate_stuck;
  } gdfp_status_t;
  typedef enum logic [1:0] {GDFP_RUN, GDFP_HOLD, GDFP_WAIT} gdfp_oc_state_t;
endpackage

// ==== hw/gdfp_top.sv ====
// fault detection, latching and recovery for a three-phase gate driver
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "gdfp_map.svh"
module gdfp_top
  import gdfp_pkg::*;
#(
  parameter int RETRY_CYC = `GDFP_RETRY_CYC,
  parameter bit HAS_REGS  = 1'b1
) (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [10:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [10:0] rdata_out,
  input  wire logic        supply_low_in,
  input  wire logic        pump_low_in,
  input  wire logic [5:0]  drain_cmp_in,
  input  wire logic        shunt_cmp_in,
  input  wire logic        drain_level_pin_off_in,
  input  wire logic [5:0]  gate_cmd_in,
  input  wire logic [5:0]  gate_sense_in,
  input  wire logic        enable_pulse_clear_in,
  output logic      [5:0]  gate_drive_out,
  output logic             pump_enable_out,
  output logic             fault_out_n
);
  logic [10:0]    cfg_reg;
  logic           clear_reg;
  gdfp_status_t   flag_reg;
  logic [5:0]     fet_flag_reg;
  logic [5:0]     gate_flag_reg;
  logic [7:0]     shunt_cnt_reg;
  logic [5:0]     drain_hit;
  logic [5:0]     gate_hit;
  logic           shunt_hit;
  logic [1:0]     policy;
  logic [7:0]     deg_cyc;
  logic [6:0]     gate_lim;
  logic           pump_chk;
  logic           shunt_chk;
  logic           gate_chk;
  logic           clear_cmd;
  logic           drain_on;
  gdfp_oc_state_t drain_st_reg;
  gdfp_oc_state_t shunt_st_reg;
  logic [31:0]    drain_wait_reg;
  logic [31:0]    shunt_wait_reg;
  logic           gate_hold_reg;

  // effective configuration; pin variant forces fixed settings
  always_comb begin
    policy    = HAS_REGS ? cfg_reg[`GDFP_CFG_POL_LSB +: 2] : `GDFP_POL_RETRY;
    pump_chk  = HAS_REGS ? !cfg_reg[`GDFP_CFG_PUMP_OFF] : 1'b1;
    shunt_chk = !(HAS_REGS && cfg_reg[`GDFP_CFG_SHUNT_OFF]) &&
                (policy != `GDFP_POL_OFF);
    gate_chk  = !(HAS_REGS && cfg_reg[`GDFP_CFG_GATE_OFF]);
    drain_on  = (policy != `GDFP_POL_OFF) &&
                !(!HAS_REGS && drain_level_pin_off_in);
    // eight bits so the longest code (128 cycles) does not wrap to zero
    deg_cyc   = HAS_REGS ? (8'(cfg_reg[`GDFP_CFG_DEG_LSB +: 3]) + 8'h01) << 4
                         : 8'(`GDFP_DEG_HW_CYC);
    gate_lim  = (7'(cfg_reg[`GDFP_CFG_DRV_LSB +: 3]) + 7'h01) << 3;
    clear_cmd = clear_reg || enable_pulse_clear_in;
  end

  // per-fet deglitch and gate timeout counters
  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_fet
      // counters wide enough to reach the longest filter and timeout
      logic [7:0] drain_cnt_reg;
      logic [6:0] gate_cnt_reg;
      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          drain_cnt_reg <= 8'h00;
          gate_cnt_reg  <= 7'h00;
        end else begin
          // only an enabled fet may trip on drain voltage
          if (drain_cmp_in[i] && gate_drive_out[i]) begin
            if (drain_cnt_reg != 8'hff) drain_cnt_reg <= drain_cnt_reg + 8'h01;
          end else begin
            drain_cnt_reg <= 8'h00;
          end
          // gate sense disagreeing with the driven gate (gate_drive_out) counts toward timeout
          if (gate_drive_out[i] != gate_sense_in[i]) begin
            if (gate_cnt_reg != 7'h7f) gate_cnt_reg <= gate_cnt_reg + 7'h01;
          end else begin
            gate_cnt_reg <= 7'h00;
          end
        end
      end
      assign drain_hit[i] = drain_on && (drain_cnt_reg >= deg_cyc);
      assign gate_hit[i]  = gate_chk && (gate_cnt_reg >= gate_lim);
    end
  endgenerate

  // shunt deglitch counter
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shunt_cnt_reg <= 8'h00;
    end else if (shunt_cmp_in) begin
      if (shunt_cnt_reg != 8'hff) shunt_cnt_reg <= shunt_cnt_reg + 8'h01;
    end else begin
      shunt_cnt_reg <= 8'h00;
    end
  end
  assign shunt_hit = shunt_chk && (shunt_cnt_reg >= deg_cyc);

  // drain overcurrent policy machine
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drain_st_reg   <= GDFP_RUN;
      drain_wait_reg <= 32'h0;
    end else begin
      case (drain_st_reg)
        GDFP_RUN: begin
          if (|drain_hit) begin
            drain_st_reg   <= (policy == `GDFP_POL_RETRY) ? GDFP_WAIT : GDFP_HOLD;
            drain_wait_reg <= 32'h0;
          end
        end
        GDFP_WAIT: begin
          if (drain_wait_reg >= 32'(RETRY_CYC - 1)) drain_st_reg <= GDFP_RUN;
          else drain_wait_reg <= drain_wait_reg + 32'h1;
        end
        GDFP_HOLD: begin
          if (clear_cmd && !(|drain_hit)) drain_st_reg <= GDFP_RUN;
        end
        default: drain_st_reg <= GDFP_RUN;
      endcase
    end
  end

  // shunt overcurrent policy machine
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shunt_st_reg   <= GDFP_RUN;
      shunt_wait_reg <= 32'h0;
    end else begin
      case (shunt_st_reg)
        GDFP_RUN: begin
          if (shunt_hit) begin
            shunt_st_reg   <= (policy == `GDFP_POL_RETRY) ? GDFP_WAIT : GDFP_HOLD;
            shunt_wait_reg <= 32'h0;
          end
        end
        GDFP_WAIT: begin
          if (shunt_wait_reg >= 32'(RETRY_CYC - 1)) shunt_st_reg <= GDFP_RUN;
          else shunt_wait_reg <= shunt_wait_reg + 32'h1;
        end
        GDFP_HOLD: begin
          if (clear_cmd && !shunt_hit) shunt_st_reg <= GDFP_RUN;
        end
        default: shunt_st_reg <= GDFP_RUN;
      endcase
    end
  end

  // gate stuck latch, held until clear or gate check off, with condition gone
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gate_hold_reg <= 1'b0;
    end else if (|gate_hit) begin
      gate_hold_reg <= 1'b1;
    end else if (clear_cmd || !gate_chk) begin
      gate_hold_reg <= 1'b0;
    end
  end

  // status flags; a new event wins over a clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_reg      <= '0;
      fet_flag_reg  <= 6'h00;
      gate_flag_reg <= 6'h00;
    end else begin
      flag_reg.supply_low <= supply_low_in ||
                             (flag_reg.supply_low && !clear_cmd);
      flag_reg.pump_low   <= (pump_chk && pump_low_in) ||
                             (flag_reg.pump_low && !clear_cmd);
      if (|drain_hit) begin
        flag_reg.drain_oc <= 1'b1;
        fet_flag_reg      <= fet_flag_reg | drain_hit;
      end else if ((drain_st_reg == GDFP_WAIT && drain_wait_reg >= 32'(RETRY_CYC - 1)) ||
                   (drain_st_reg != GDFP_WAIT && clear_cmd)) begin
        flag_reg.drain_oc <= 1'b0;
        fet_flag_reg      <= 6'h00;
      end
      if (shunt_hit) begin
        flag_reg.shunt_oc <= 1'b1;
      end else if ((shunt_st_reg == GDFP_WAIT && shunt_wait_reg >= 32'(RETRY_CYC - 1)) ||
                   (shunt_st_reg != GDFP_WAIT && clear_cmd)) begin
        flag_reg.shunt_oc <= 1'b0;
      end
      if (|gate_hit) begin
        flag_reg.gate_stuck <= 1'b1;
        gate_flag_reg       <= gate_flag_reg | gate_hit;
      end else if (clear_cmd) begin
        flag_reg.gate_stuck <= 1'b0;
        gate_flag_reg       <= 6'h00;
      end
      flag_reg.global <= supply_low_in || (pump_chk && pump_low_in) ||
                         (|drain_hit) || shunt_hit || (|gate_hit) ||
                         (flag_reg.global && !clear_cmd);
    end
  end

  // gate, pump and fault pin outputs
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gate_drive_out  <= 6'h00;
      pump_enable_out <= 1'b0;
      fault_out_n     <= 1'b1;
    end else begin
      pump_enable_out <= !supply_low_in;
      if (supply_low_in || (pump_chk && pump_low_in) || gate_hold_reg || (|gate_hit) ||
          (drain_st_reg != GDFP_RUN && policy != `GDFP_POL_REPORT) ||
          (shunt_st_reg != GDFP_RUN && policy != `GDFP_POL_REPORT))
        gate_drive_out <= 6'h00;
      else
        gate_drive_out <= gate_cmd_in;
      // gate fault pulls the pin in the same cycle the gates drop
      fault_out_n <= !(supply_low_in || (pump_chk && pump_low_in) || gate_hold_reg || (|gate_hit) ||
                       drain_st_reg != GDFP_RUN || shunt_st_reg != GDFP_RUN);
    end
  end

  // register writes; clear command self-clears
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_reg   <= `GDFP_CFG_RESET;
      clear_reg <= 1'b0;
    end else begin
      clear_reg <= wr_in && addr_in == `GDFP_ADDR_CTRL && wdata_in[`GDFP_CTRL_CLEAR];
      if (wr_in && addr_in == `GDFP_ADDR_CFG) cfg_reg <= wdata_in;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 11'h000;
    end else if (rd_in) begin
      case (addr_in)
        `GDFP_ADDR_CFG:    rdata_out <= cfg_reg;
        `GDFP_ADDR_STATUS: rdata_out <= {5'h00, flag_reg};
        `GDFP_ADDR_FET:    rdata_out <= {gate_flag_reg[4:0], fet_flag_reg};
        default:           rdata_out <= 11'h000;
      endcase
    end else begin
      rdata_out <= 11'h000;
    end
  end
endmodule

// ==== testbench/gdfp_properties.sv ====
// concurrent checks on the fault protection ports
`timescale 1ns/1ps
module gdfp_properties (
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic [3:0]  addr_in,
  input wire logic        rd_in,
  input wire logic [10:0] rdata_out,
  input wire logic        supply_low_in,
  input wire logic        pump_low_in,
  input wire logic [5:0]  drain_cmp_in,
  input wire logic        shunt_cmp_in,
  input wire logic [5:0]  gate_cmd_in,
  input wire logic [5:0]  gate_sense_in,
  input wire logic [5:0]  gate_drive_out,
  input wire logic        pump_enable_out,
  input wire logic        fault_out_n
);
  logic cause;
  // any raw source that may pull the fault pin low
  assign cause = supply_low_in | pump_low_in | shunt_cmp_in | (|drain_cmp_in)
               | (gate_sense_in != gate_drive_out);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 11'h000)
    else $error("read data seen without a read");
  unmapped_read_a: assert property (rd_in && addr_in > 4'h3 |=> rdata_out == 11'h000)
    else $error("unmapped read not zero");
  supply_off_a: assert property (supply_low_in |=>
    !pump_enable_out && gate_drive_out == 6'h00 && !fault_out_n)
    else $error("supply low did not shut down");
  pump_track_a: assert property ($past(reset_n_in) |->
    pump_enable_out == !$past(supply_low_in))
    else $error("pump enable wrong");
  fault_cause_a: assert property ($fell(fault_out_n) |-> $past(cause))
    else $error("fault without a cause");
  fault_rise_a: assert property ($rose(fault_out_n) |-> !$past(supply_low_in))
    else $error("fault released during supply low");
  gates_follow_a: assert property (fault_out_n && $past(fault_out_n)
    && $past(pump_enable_out) && !$past(pump_low_in) |-> gate_drive_out == $past(gate_cmd_in))
    else $error("gates not as commanded");
  gate_subset_a: assert property ((gate_drive_out & ~$past(gate_cmd_in)) == 6'h00)
    else $error("uncommanded gate driven");
  cover property ($fell(fault_out_n));
  cover property ($rose(fault_out_n));
  cover property (rd_in && addr_in > 4'h3);
endmodule

// ==== testbench/gdfp_ctrl_model.sv ====
// gate feedback and enable-pulse clear from the controller side
`timescale 1ns/1ps
module gdfp_ctrl_model (
  input  wire logic       sys_clk_in,
  input  wire logic [5:0] gate_drive_in,
  input  wire logic [5:0] stuck_in,
  input  wire logic       clr_req_in,
  output logic      [5:0] gate_sense_out = 6'h00,
  output logic            clr_pulse_out = 1'b0
);
  logic clr_req_reg = 1'b0;
  // measured gates lag the drive one cycle, stuck bits never rise
  always @(posedge sys_clk_in) begin
    gate_sense_out <= gate_drive_in & ~stuck_in;
  end
  // high-low-high on enable seen as one high pulse
  always @(posedge sys_clk_in) begin
    clr_req_reg <= clr_req_in;
    clr_pulse_out <= clr_req_in & ~clr_req_reg;
  end
endmodule

// ==== testbench/gdfp_top_bench.sv ====
// self-checking bench for the fault protection block
`timescale 1ns/1ps
`include "gdfp_map.svh"
module gdfp_top_bench;
  logic        sys_clk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0, clr_req = 0;
  logic        supply_low_in = 0, pump_low_in = 0, shunt_cmp_in = 0, drain_level_pin_off_in = 0;
  logic        enable_pulse_clear_in, pump_enable_out, fault_out_n;
  logic [3:0]  addr_in = 4'h0;
  logic [10:0] wdata_in = 11'h000, rdata_out, rd_val;
  logic [5:0]  drain_cmp_in = 6'h00, gate_cmd_in = 6'h3f, stuck = 6'h00;
  logic [5:0]  gate_sense_in, gate_drive_out;
  int          miscompares = 0, cmp_count = 0;
  bit   [31:0] seed = 52742;
  gdfp_top #(.RETRY_CYC(50)) i_gdfp_top (.*);
  gdfp_ctrl_model i_gdfp_ctrl_model (.sys_clk_in(sys_clk_in), .gate_drive_in(gate_drive_out),
    .stuck_in(stuck), .clr_req_in(clr_req), .gate_sense_out(gate_sense_in),
    .clr_pulse_out(enable_pulse_clear_in));
  always #25 sys_clk_in = ~sys_clk_in;
  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // gates expected while a drain trip is held, per policy
  function automatic logic [5:0] gates_for(input logic [1:0] p);
    return (p == `GDFP_POL_LATCH || p == `GDFP_POL_RETRY) ? 6'h00 : 6'h3f;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 rd_val = rdata_out;
  endtask
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic out(input logic f, input logic [5:0] g);
    chk("fault_out_n", 11'(f), 11'(fault_out_n));
    chk("gate_drive_out", 11'(g), 11'(gate_drive_out));
  endtask
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog well past the expected run length
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    cyc(8);
    reset_n_in <= 1'b1;
    cyc(3);
    out(1'b1, 6'h3f);
    rd(4'h9);
    chk("unmapped", 11'h000, rd_val);
    // random short drain glitches, none reaches the filter length
    for (int i = 0; i < 8; i++) begin
      drain_cmp_in <= 6'h01 << (xs() % 6);
      cyc(xs() % 15 + 1);
      drain_cmp_in <= 6'h00;
      cyc(2);
      out(1'b1, 6'h3f);
      gate_cmd_in <= 6'(xs());
      cyc(3);
      out(1'b1, gate_cmd_in);
      gate_cmd_in <= 6'h3f;
    end
    supply_low_in <= 1'b1;
    cyc(3);
    out(1'b0, 6'h00);
    chk("pump_enable_out", 11'h000, 11'(pump_enable_out));
    supply_low_in <= 1'b0;
    cyc(3);
    out(1'b1, 6'h3f);
    rd(`GDFP_ADDR_STATUS);
    chk("supply_flag", 11'h010, rd_val & 11'h010);
    wr(`GDFP_ADDR_CTRL, 11'h001);
    rd(`GDFP_ADDR_STATUS);
    chk("supply_flag", 11'h000, rd_val & 11'h010);
    pump_low_in <= 1'b1;
    cyc(3);
    out(1'b0, 6'h00);
    wr(`GDFP_ADDR_CFG, 11'h004);
    cyc(3);
    out(1'b1, 6'h3f);
    pump_low_in <= 1'b0;
    // every overcurrent policy on a held drain trip
    for (int p = 0; p < 4; p++) begin
      wr(`GDFP_ADDR_CFG, 11'(p));
      wr(`GDFP_ADDR_CTRL, 11'h001);
      drain_cmp_in <= 6'h01;
      cyc(30);
      out(p == `GDFP_POL_OFF, gates_for(2'(p)));
      rd(`GDFP_ADDR_FET);
      chk("fet_flag", 11'(p != `GDFP_POL_OFF), rd_val & 11'h001);
      drain_cmp_in <= 6'h00;
      cyc(p == `GDFP_POL_RETRY ? 60 : 5);
      out(p >= `GDFP_POL_RETRY && p != `GDFP_POL_REPORT, gates_for(2'(p)) | {6{p != 0}});
      wr(`GDFP_ADDR_CTRL, 11'h001);
      cyc(3);
      out(1'b1, 6'h3f);
    end
    // longest filter code: 128 cycles before a latched trip
    wr(`GDFP_ADDR_CFG, 11'h0e0);
    drain_cmp_in <= 6'h04;
    cyc(100);
    out(1'b1, 6'h3f);
    cyc(40);
    out(1'b0, 6'h00);
    drain_cmp_in <= 6'h00;
    wr(`GDFP_ADDR_CTRL, 11'h001);
    cyc(3);
    out(1'b1, 6'h3f);
    wr(`GDFP_ADDR_CFG, 11'h008);
    shunt_cmp_in <= 1'b1;
    cyc(30);
    out(1'b1, 6'h3f);
    wr(`GDFP_ADDR_CFG, 11'h000);
    cyc(30);
    out(1'b0, 6'h00);
    shunt_cmp_in <= 1'b0;
    wr(`GDFP_ADDR_CTRL, 11'h001);
    cyc(3);
    out(1'b1, 6'h3f);
    stuck <= 6'h01;
    cyc(20);
    out(1'b0, 6'h00);
    stuck <= 6'h00;
    clr_req <= 1'b1;
    cyc(2);
    clr_req <= 1'b0;
    cyc(3);
    out(1'b1, 6'h3f);
    wr(`GDFP_ADDR_CFG, 11'h010);
    stuck <= 6'h02;
    cyc(20);
    out(1'b1, 6'h3f);
    conclude();
  end
endmodule
bind gdfp_top gdfp_properties i_gdfp_properties (.*);
